// File: common/oml_map.svh
`ifndef OML_MAP_SVH
`define OML_MAP_SVH
// command opcodes
`define OML_OP_WREN 8'h06
`define OML_OP_WRDI 8'h04
`define OML_OP_GETF 8'h0F
`define OML_OP_SETF 8'h1F
`define OML_OP_PEXE 8'h10
`define OML_OP_PRD 8'h13
`define OML_OP_ERS 8'hD8
`define OML_OP_PROT 8'h2C
`define OML_OP_RST 8'hFF
// feature addresses
`define OML_FA_CFG 8'hB0
`define OML_FA_STAT 8'hC0
// configuration field positions and reset value
`define OML_CFG_HI 7
`define OML_CFG_MID 6
`define OML_CFG_LO 1
`define OML_CFG_ECC 4
`define OML_CFG_RST 8'h10
// page addresses
`define OML_PG_UID 16'h0000
`define OML_PG_PARAM 16'h0001
`define OML_PG_FIRST 16'h0002
`define OML_PG_LAST 16'h000B
// correction result after clear
`define OML_ECC_NONE 3'h0
// busy lengths in clock cycles
`define OML_NV_BUSY 64
`define OML_RST_BUSY 16
`endif

// File: common/oml_pkg.sv
package oml_pkg;
  // decoded configuration mode
  typedef enum logic [1:0] {
    OML_NORMAL = 2'b00,
    OML_OTP = 2'b01,
    OML_PROT = 2'b10,
    OML_BOOTDIS = 2'b11
  } oml_mode_t;
  // control sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ENG = 2'b01,
    ST_TIMED = 2'b10,
    ST_INIT = 2'b11
  } oml_state_t;
  // array engine operation
  typedef enum logic [1:0] {
    ENG_READ = 2'b00,
    ENG_PROG = 2'b01,
    ENG_ERASE = 2'b10,
    ENG_PROT = 2'b11
  } oml_eng_op_t;
  // array engine target area
  typedef enum logic [1:0] {
    TGT_MAIN = 2'b00,
    TGT_OTP = 2'b01,
    TGT_UID = 2'b10,
    TGT_PARAM = 2'b11
  } oml_tgt_t;
  typedef struct packed {
    logic valid;
    oml_eng_op_t op;
    oml_tgt_t tgt;
    logic [15:0] page;
    logic ecc_on;
    logic clear_only;
  } oml_eng_req_t;
  typedef struct packed {
    logic done;
    logic fail;
    logic [2:0] ecc;
  } oml_eng_rsp_t;
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
  } oml_pins_t;
endpackage

// File: design/oml_otp_ctrl.sv
`timescale 1ns/1ns
`include "oml_map.svh"
// How it works
// - otp bits only clear, never erased
// - ten otp pages at 02h..0Bh, ascending
// - config bits decode into four modes
// - B0h 40h/50h enters otp mode
// - otp mode routes program/read to otp
// - erase ignored in otp mode
// - otp page 00h uid, 01h parameter
// - out-of-range otp program fails, ignored
// - protected otp area refuses program
// - read beyond range gives invalid data
// - B0h 00h/10h returns to normal
// - reset command leaves otp mode
// - C0h then program execute locks otp
// - repeated lock ignored, status 00h
// - C2h then program execute disables boot protect
// - repeated disable ignored, status 00h
// - status register read at C0h
// - bit 0 busy during operations
// - bit 1 write latch set/cleared
// - bit 2 erase fail set/cleared
// - bit 3 program fail set/cleared
// - bits 6:4 correction result codes
// - correction field cleared per read, power-up read
// - protect ignored once boot disable taken
// - config bit 4 enables ecc
module oml_otp_ctrl #(
  parameter int unsigned NV_BUSY_CYC = `OML_NV_BUSY,
  parameter int unsigned RST_BUSY_CYC = `OML_RST_BUSY
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire oml_pkg::oml_pins_t pins,
  output logic so,
  output logic so_oe_n,
  output oml_pkg::oml_eng_req_t eng_req,
  input wire oml_pkg::oml_eng_rsp_t eng_rsp
);
  import oml_pkg::*;

  // ***************
  // checks and helpers
  // ***************
  generate
    if (NV_BUSY_CYC < 2 || NV_BUSY_CYC > 65535 ||
        RST_BUSY_CYC < 1 || RST_BUSY_CYC > 65535)
    begin : g_bad
      $error("busy counts out of range");
    end
  endgenerate

  // config byte to mode
  function automatic oml_mode_t mode_of(input logic [7:0] c);
    logic [2:0] s;
    s = {c[`OML_CFG_HI], c[`OML_CFG_MID], c[`OML_CFG_LO]};
    unique case (s)
      3'b010: mode_of = OML_OTP;
      3'b110: mode_of = OML_PROT;
      3'b111: mode_of = OML_BOOTDIS;
      default: mode_of = OML_NORMAL; // reserved codes act normal
    endcase
  endfunction

  // build an engine request
  function automatic oml_eng_req_t mk_req(input oml_eng_op_t op,
      input oml_tgt_t tgt, input logic [15:0] pg, input logic ecc);
    mk_req.valid = 1'b1;
    mk_req.op = op;
    mk_req.tgt = tgt;
    mk_req.page = pg;
    mk_req.ecc_on = ecc;
    mk_req.clear_only = (tgt == TGT_OTP);
  endfunction

  // ***************
  // pin synchronisers
  // ***************
  oml_pins_t pins_q1; // first stage, read only by second
  oml_pins_t pins_q2; // safe sampled pins
  logic sck_q3; // previous clock level
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pins_q1 <= 3'h2;
      pins_q2 <= 3'h2;
      sck_q3 <= 1'b0;
    end
    else
    begin
      pins_q1 <= pins;
      pins_q2 <= pins_q1;
      sck_q3 <= pins_q2.sck;
    end
  end

  wire cs_idle = pins_q2.cs_n; // frame closed
  wire sck_rise = pins_q2.sck & ~sck_q3 & ~cs_idle;
  wire sck_fall = ~pins_q2.sck & sck_q3 & ~cs_idle;

  // ***************
  // serial receiver
  // ***************
  logic [2:0] bit_cnt_r; // bit within byte
  logic [2:0] byte_cnt_r; // bytes seen, saturates at 4
  logic [6:0] sh_r; // partial byte
  logic [7:0] opc_r; // frame opcode
  logic [7:0] fa_r; // feature address
  logic [7:0] addr_r; // high page address byte
  wire [7:0] byte_in = {sh_r, pins_q2.si};
  wire byte_done = sck_rise & (bit_cnt_r == 3'h7);
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 3'h0;
      sh_r <= 7'h00;
      opc_r <= 8'h00;
      fa_r <= 8'h00;
      addr_r <= 8'h00;
    end
    else if (cs_idle)
    begin
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 3'h0;
    end
    else if (sck_rise)
    begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      sh_r <= byte_in[6:0];
      if (byte_done && byte_cnt_r != 3'h4)
        byte_cnt_r <= byte_cnt_r + 3'h1;
      if (byte_done && byte_cnt_r == 3'h0)
        opc_r <= byte_in;
      if (byte_done && byte_cnt_r == 3'h1)
        fa_r <= byte_in;
      if (byte_done && byte_cnt_r == 3'h2)
        addr_r <= byte_in;
    end
  end

  // ***************
  // command decode
  // ***************
  oml_state_t state_r; // sequencer
  logic [7:0] cfg_r; // configuration feature
  logic wel_r; // write_latch_flag
  logic efail_r; // erase fail
  logic pfail_r; // program fail
  logic [2:0] ecc_r; // correction_result_field
  logic otp_prot_r; // otp area locked
  logic boot_dis_r; // boot protection disabled
  oml_mode_t timed_r; // kind of timed operation
  logic [15:0] tmr_r; // timed operation counter
  oml_eng_req_t eng_req_r; // engine request
  wire idle = (state_r == ST_IDLE);
  wire oml_mode_t mode = mode_of(cfg_r);
  wire ecc_en = cfg_r[`OML_CFG_ECC];
  wire op0 = byte_done & (byte_cnt_r == 3'h0);
  wire cmd_rst = op0 & (byte_in == `OML_OP_RST);
  wire cmd_wren = op0 & idle & (byte_in == `OML_OP_WREN);
  wire cmd_wrdi = op0 & idle & (byte_in == `OML_OP_WRDI);
  wire cmd_setf = byte_done & idle & (byte_cnt_r == 3'h2) & (opc_r == `OML_OP_SETF);
  wire a3 = byte_done & idle & (byte_cnt_r == 3'h3);
  wire cmd_pe = a3 & (opc_r == `OML_OP_PEXE) & wel_r;
  wire cmd_rd = a3 & (opc_r == `OML_OP_PRD);
  wire cmd_ers = a3 & (opc_r == `OML_OP_ERS) & wel_r;
  wire cmd_prot = a3 & (opc_r == `OML_OP_PROT) & wel_r;
  wire [15:0] pg = {addr_r, byte_in}; // page/block address
  wire otp_pg_ok = (pg >= `OML_PG_FIRST) && (pg <= `OML_PG_LAST);
  wire [7:0] status = {1'b0, ecc_r, pfail_r, efail_r, wel_r, ~idle};
  wire getf_load = byte_done & (byte_cnt_r != 3'h0) & (opc_r == `OML_OP_GETF);
  wire [7:0] fa_sel = (byte_cnt_r == 3'h1) ? byte_in : fa_r;
  wire [7:0] feat = (fa_sel == `OML_FA_STAT) ? status :
                    (fa_sel == `OML_FA_CFG) ? cfg_r : 8'h00;
  wire oml_tgt_t rd_tgt = (mode != OML_OTP) ? TGT_MAIN :
                          (pg == `OML_PG_UID) ? TGT_UID :
                          (pg == `OML_PG_PARAM) ? TGT_PARAM : TGT_OTP;

  // ***************
  // control sequencer
  // ***************
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= ST_INIT;
      cfg_r <= `OML_CFG_RST;
      wel_r <= 1'b0;
      efail_r <= 1'b0;
      pfail_r <= 1'b0;
      ecc_r <= `OML_ECC_NONE;
      otp_prot_r <= 1'b0;
      boot_dis_r <= 1'b0;
      timed_r <= OML_NORMAL;
      tmr_r <= 16'h0000;
      eng_req_r <= '0;
    end
    else
    begin
      eng_req_r.valid <= 1'b0;
      if (cmd_rst)
      begin
        // abort, leave otp mode, clear status
        cfg_r[`OML_CFG_HI] <= 1'b0;
        cfg_r[`OML_CFG_MID] <= 1'b0;
        cfg_r[`OML_CFG_LO] <= 1'b0;
        wel_r <= 1'b0;
        efail_r <= 1'b0;
        pfail_r <= 1'b0;
        ecc_r <= `OML_ECC_NONE;
        state_r <= ST_TIMED;
        timed_r <= OML_NORMAL;
        tmr_r <= 16'(RST_BUSY_CYC);
      end
      else
      begin
        unique case (state_r)
          ST_INIT:
          begin
            // power-up read of block 0 page 0
            eng_req_r <= mk_req(ENG_READ, TGT_MAIN, 16'h0000, ecc_en);
            state_r <= ST_ENG;
          end
          ST_IDLE:
          begin
            if (cmd_wren)
              wel_r <= 1'b1;
            if (cmd_wrdi)
              wel_r <= 1'b0;
            if (cmd_setf && fa_r == `OML_FA_CFG)
              cfg_r <= byte_in;
            if (cmd_rd)
            begin
              ecc_r <= `OML_ECC_NONE;
              eng_req_r <= mk_req(ENG_READ, rd_tgt, pg, ecc_en);
              state_r <= ST_ENG;
            end
            if (cmd_ers && mode != OML_OTP)
            begin
              efail_r <= 1'b0;
              eng_req_r <= mk_req(ENG_ERASE, TGT_MAIN, pg, ecc_en);
              state_r <= ST_ENG;
            end
            if (cmd_prot && !boot_dis_r)
            begin
              pfail_r <= 1'b0;
              eng_req_r <= mk_req(ENG_PROT, TGT_MAIN, pg, ecc_en);
              state_r <= ST_ENG;
            end
            if (cmd_pe)
            begin
              pfail_r <= 1'b0;
              unique case (mode)
                OML_NORMAL:
                begin
                  eng_req_r <= mk_req(ENG_PROG, TGT_MAIN, pg, ecc_en);
                  state_r <= ST_ENG;
                end
                OML_OTP:
                begin
                  if (otp_pg_ok && !otp_prot_r)
                  begin
                    eng_req_r <= mk_req(ENG_PROG, TGT_OTP, pg, ecc_en);
                    state_r <= ST_ENG;
                  end
                  else
                    pfail_r <= 1'b1;
                end
                OML_PROT, OML_BOOTDIS:
                begin
                  if (mode == OML_PROT ? otp_prot_r : boot_dis_r)
                  begin
                    // already done: ignore, status reads 00h
                    wel_r <= 1'b0;
                    efail_r <= 1'b0;
                    ecc_r <= `OML_ECC_NONE;
                  end
                  else
                  begin
                    state_r <= ST_TIMED;
                    timed_r <= mode;
                    tmr_r <= 16'(NV_BUSY_CYC);
                  end
                end
              endcase
            end
          end
          ST_ENG:
          begin
            // engine completion updates status
            if (eng_rsp.done)
            begin
              state_r <= ST_IDLE;
              unique case (eng_req_r.op)
                ENG_READ: ecc_r <= eng_rsp.ecc;
                ENG_ERASE:
                  if (eng_rsp.fail)
                    efail_r <= 1'b1;
                  else
                    wel_r <= 1'b0;
                ENG_PROG, ENG_PROT:
                  if (eng_rsp.fail)
                    pfail_r <= 1'b1;
                  else
                    wel_r <= 1'b0;
              endcase
            end
          end
          ST_TIMED:
          begin
            // internal busy period
            if (tmr_r == 16'h0001)
            begin
              state_r <= ST_IDLE;
              if (timed_r == OML_PROT)
                otp_prot_r <= 1'b1;
              if (timed_r == OML_BOOTDIS)
                boot_dis_r <= 1'b1;
              if (timed_r != OML_NORMAL)
                wel_r <= 1'b0;
            end
            else
              tmr_r <= tmr_r - 16'h0001;
          end
        endcase
      end
    end
  end
  assign eng_req = eng_req_r;

  // ***************
  // serial transmitter
  // ***************
  logic [7:0] out_r; // outgoing byte
  logic tx_en_r; // data phase of get feature
  logic so_r; // output pin
  logic so_oe_n_r; // low while driving
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      out_r <= 8'h00;
      tx_en_r <= 1'b0;
      so_r <= 1'b0;
      so_oe_n_r <= 1'b1;
    end
    else if (cs_idle)
    begin
      tx_en_r <= 1'b0;
      so_oe_n_r <= 1'b1;
    end
    else if (getf_load)
    begin
      out_r <= feat; // reloaded each byte for live polling
      tx_en_r <= 1'b1;
    end
    else if (sck_fall && tx_en_r)
    begin
      so_r <= out_r[7];
      out_r <= {out_r[6:0], 1'b0};
      so_oe_n_r <= 1'b0;
    end
  end
  assign so = so_r;
  assign so_oe_n = so_oe_n_r;

  // ***************
  // assertions
  // ***************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_wel_set: assert property (cmd_wren && !cmd_rst |=> wel_r)
    else $error("write latch not set");
  a_otp_route: assert property (cmd_pe && mode == OML_OTP && otp_pg_ok && !otp_prot_r
      |=> eng_req_r.valid && eng_req_r.tgt == TGT_OTP && eng_req_r.clear_only)
    else $error("otp program not routed");
  a_erase_block: assert property (a3 && opc_r == `OML_OP_ERS && mode == OML_OTP
      && !cmd_rst |=> !eng_req_r.valid && idle)
    else $error("erase accepted in otp mode");
  a_range_fail: assert property (cmd_pe && mode == OML_OTP && !otp_pg_ok
      |=> pfail_r && idle && !eng_req_r.valid)
    else $error("bad otp page not refused");
  a_lock_again: assert property (cmd_pe && mode == OML_PROT && otp_prot_r
      && efail_r == 1'b0 |=> status == 8'h00)
    else $error("repeated lock status not 00h");
  a_rst_exit: assert property (cmd_rst |=> mode == OML_NORMAL && state_r == ST_TIMED
      ##1 status[0])
    else $error("reset did not leave otp mode");
  a_lock_busy: assert property (cmd_pe && mode == OML_PROT && !otp_prot_r
      |=> (state_r == ST_TIMED && status[0])[*2])
    else $error("lock not busy");
  a_read_clear: assert property (cmd_rd && !cmd_rst |=> ecc_r == `OML_ECC_NONE
      && eng_req_r.op == ENG_READ)
    else $error("read did not clear ecc");
  a_prot_skip: assert property (cmd_prot && boot_dis_r |=> idle && !eng_req_r.valid)
    else $error("protect not skipped");
endmodule

// File: dv/oml_host_model.sv
`timescale 1ns/1ns
// ****************************************
// host spi controller, mode 0, sck idles low
// ****************************************
module oml_host_model (
  input wire logic clock,
  output oml_pkg::oml_pins_t pins,
  input wire logic so,
  input wire logic so_oe_n
);
  import oml_pkg::*;
  localparam int HALF = 5; // half of the 80 ns sck period
  initial pins = '{sck: 1'b0, cs_n: 1'b1, si: 1'b0};
  // one byte out msb first, so sampled at each sck rise
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      pins.si <= tx[i];
      repeat (HALF) @(posedge clock);
      // released output shows the inverse, so an undriven bit is caught
      rx[i] = so_oe_n ? ~so : so;
      pins.sck <= 1'b1;
      repeat (HALF) @(posedge clock);
      pins.sck <= 1'b0;
    end
  endtask
  // whole frame of n bytes taken from the top of tx
  task automatic frame(input logic [31:0] tx, input int n);
    logic [7:0] rx;
    @(posedge clock);
    pins.cs_n <= 1'b0;
    for (int k = 0; k < n; k++)
      shift(tx[31-8*k -: 8], rx);
    repeat (HALF) @(posedge clock);
    pins.cs_n <= 1'b1;
    pins.si <= ~pins.si; // released line, no stale level
    repeat (2 * HALF) @(posedge clock);
  endtask
  // get feature at addr, one byte back
  task automatic get_feat(input logic [7:0] addr, output logic [7:0] val);
    logic [7:0] rx;
    @(posedge clock);
    pins.cs_n <= 1'b0;
    shift(8'h0F, rx);
    shift(addr, rx);
    shift(8'h00, val);
    repeat (HALF) @(posedge clock);
    pins.cs_n <= 1'b1;
    pins.si <= ~pins.si;
    repeat (2 * HALF) @(posedge clock);
  endtask
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ns
`include "oml_map.svh"
module tb_top;
  import oml_pkg::*;
  // ****************************************
  // clock, reset, engine stand-in
  // ****************************************
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  oml_pins_t pins;
  logic so;
  logic so_oe_n;
  oml_eng_req_t eng_req;
  oml_eng_rsp_t eng_rsp = '0;
  oml_eng_req_t last_req = '0; // last engine request
  int n_req = 0; // engine requests seen
  int pend = 0; // engine busy countdown
  logic [2:0] ecc_next = 3'h3; // code the engine hands back
  logic fail_next = 1'b0; // fail flag the engine hands back
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #4 clock = ~clock;
  oml_otp_ctrl #(.NV_BUSY_CYC(400), .RST_BUSY_CYC(2)) i_dut (.clock(clock),
    .sys_rst(sys_rst), .pins(pins), .so(so), .so_oe_n(so_oe_n),
    .eng_req(eng_req), .eng_rsp(eng_rsp));
  oml_host_model i_host (.clock(clock), .pins(pins), .so(so), .so_oe_n(so_oe_n));
  // slow engine: answers 400 cycles after each request
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (eng_req.valid === 1'b1)
    begin
      n_req <= n_req + 1;
      last_req <= eng_req;
      pend <= 400;
    end
    else if (pend > 0)
      pend <= pend - 1;
    eng_rsp.done <= (pend == 1);
    eng_rsp.ecc <= ecc_next;
    eng_rsp.fail <= fail_next;
    if (cyc == 90000)
    begin
      n_mismatch++;
      $display("Error timeout expected finish seen hang");
      end_of_test();
    end
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic feat(input logic [7:0] fa, input logic [7:0] exp, input string what);
    logic [7:0] s;
    i_host.get_feat(fa, s);
    chk(what, {8'h00, exp}, {8'h00, s});
    chk("so oe idle", 16'h0001, {15'h0000, so_oe_n});
  endtask
  task automatic stat(input logic [7:0] exp, input string what);
    feat(`OML_FA_STAT, exp, what);
  endtask
  task automatic wait_ready();
    logic [7:0] s;
    s = 8'h01;
    for (int i = 0; i < 40 && s[0] !== 1'b0; i++)
      i_host.get_feat(`OML_FA_STAT, s);
    chk("ready", 16'h0000, {15'h0000, s[0]});
  endtask
  task automatic setf(input logic [7:0] v);
    i_host.frame({8'h1F, `OML_FA_CFG, v, 8'h00}, 3);
  endtask
  task automatic op4(input logic [7:0] opc, input logic [7:0] pg);
    i_host.frame({opc, 8'h00, 8'h00, pg}, 4);
  endtask
  task automatic wren();
    i_host.frame({`OML_OP_WREN, 24'h000000}, 1);
  endtask
  task automatic chk_req(input oml_eng_op_t op, input oml_tgt_t tgt, input logic [7:0] pg);
    chk("req op tgt", {12'h000, op, tgt}, {12'h000, last_req.op, last_req.tgt});
    chk("req page", {8'h00, pg}, last_req.page);
  endtask
  // lock or boot-disable sequence, then ready
  task automatic nv_seq(input logic [7:0] v, input logic look_busy);
    setf(v);
    wren();
    op4(`OML_OP_PEXE, 8'h00);
    if (look_busy)
      stat(8'h03, "nv busy");
    wait_ready();
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_power();
    wait_ready();
    chk("pwr reads", 16'h0001, n_req[15:0]);
    chk_req(ENG_READ, TGT_MAIN, 8'h00);
    stat(8'h30, "pwr ecc");
    feat(`OML_FA_CFG, 8'h10, "cfg rst");
  endtask
  task automatic t_ecc();
    logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h7, 3'h0};
    foreach (codes[i])
    begin
      ecc_next = codes[i];
      op4(`OML_OP_PRD, 8'h07);
      stat(8'h01, "read busy");
      wait_ready();
      stat({1'b0, codes[i], 4'h0}, "ecc code");
      chk("ecc on", 16'h0001, {15'h0000, last_req.ecc_on});
    end
  endtask
  task automatic t_otp();
    int n;
    setf(8'h50);
    feat(`OML_FA_CFG, 8'h50, "cfg otp");
    op4(`OML_OP_PRD, 8'h00);
    wait_ready();
    chk_req(ENG_READ, TGT_UID, 8'h00);
    op4(`OML_OP_PRD, 8'h01);
    wait_ready();
    chk_req(ENG_READ, TGT_PARAM, 8'h01);
    op4(`OML_OP_PRD, 8'h05);
    wait_ready();
    chk_req(ENG_READ, TGT_OTP, 8'h05);
    wren();
    op4(`OML_OP_PEXE, 8'h02);
    wait_ready();
    chk_req(ENG_PROG, TGT_OTP, 8'h02);
    chk("clear only", 16'h0001, {15'h0000, last_req.clear_only});
    stat(8'h00, "wel after prog");
    wren();
    n = n_req;
    op4(`OML_OP_ERS, 8'h40);
    stat(8'h02, "erase in otp");
    chk("erase req", n[15:0], n_req[15:0]);
    op4(`OML_OP_PEXE, 8'h0C);
    stat(8'h0A, "range pfail");
    chk("range req", n[15:0], n_req[15:0]);
    i_host.frame({`OML_OP_RST, 24'h000000}, 1);
    wait_ready();
    stat(8'h00, "after reset");
    feat(`OML_FA_CFG, 8'h10, "cfg reset");
  endtask
  task automatic t_lock();
    int n;
    nv_seq(8'hC0, 1'b1);
    stat(8'h00, "lock done");
    nv_seq(8'hC0, 1'b0);
    stat(8'h00, "lock again");
    setf(8'h40);
    wren();
    n = n_req;
    op4(`OML_OP_PEXE, 8'h03);
    stat(8'h0A, "prot pfail");
    chk("prot req", n[15:0], n_req[15:0]);
    op4(`OML_OP_PRD, 8'h03);
    wait_ready();
    chk_req(ENG_READ, TGT_OTP, 8'h03);
    chk("prot ecc off", 16'h0000, {15'h0000, last_req.ecc_on});
    setf(8'h10);
    feat(`OML_FA_CFG, 8'h10, "cfg exit");
  endtask
  task automatic t_boot();
    int n;
    nv_seq(8'hC2, 1'b1);
    stat(8'h00, "bootdis done");
    nv_seq(8'hC2, 1'b0);
    stat(8'h00, "bootdis again");
    setf(8'h10);
    wren();
    n = n_req;
    op4(`OML_OP_PROT, 8'h00);
    stat(8'h02, "protect ignored");
    chk("protect req", n[15:0], n_req[15:0]);
    i_host.frame({`OML_OP_WRDI, 24'h000000}, 1);
    stat(8'h00, "wrdi");
  endtask
  // engine failures in normal mode set both fail bits, and a passing erase clears the erase fail bit
  task automatic t_fail();
    fail_next = 1'b1;
    wren();
    op4(`OML_OP_ERS, 8'h40);
    wait_ready();
    chk_req(ENG_ERASE, TGT_MAIN, 8'h40);
    stat(8'h06, "erase fail");
    op4(`OML_OP_PEXE, 8'h05);
    wait_ready();
    chk_req(ENG_PROG, TGT_MAIN, 8'h05);
    stat(8'h0E, "prog fail");
    fail_next = 1'b0;
    op4(`OML_OP_ERS, 8'h41);
    stat(8'h0B, "erase busy");
    wait_ready();
    stat(8'h08, "erase pass");
  endtask
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    t_power();
    t_ecc();
    t_otp();
    t_lock();
    t_boot();
    t_fail();
    end_of_test();
  end
endmodule
